/* design/bpop_regs.svh */
// Purpose: offsets, fields and reset values of the port block
// Assumes: byte-wide registers on a plain strobe port
// Notes:   included by bare name
`ifndef BPOP_REGS_SVH
`define BPOP_REGS_SVH

`define BPOP_ADDR_W          4
`define BPOP_OFF_PIN_VALUE   4'h0
`define BPOP_OFF_DIRECTION   4'h1
`define BPOP_OFF_LATCH       4'h2
`define BPOP_OFF_ANALOG      4'h3
`define BPOP_OFF_CONFIG      4'h4
`define BPOP_OFF_SET         4'h5
`define BPOP_OFF_CLEAR       4'h6
`define BPOP_OFF_TOGGLE      4'h7
`define BPOP_INPUT_ONLY_BIT  5
`define BPOP_CFG_RESET_FUSE  0
`define BPOP_CFG_LOW_VOLT    1
`define BPOP_DIR_RESET       8'hff
`define BPOP_LATCH_RESET     8'h00
`define BPOP_ANALOG_RESET    8'hff
`define BPOP_CONFIG_RESET    8'h00

`endif

/* design/bpop_pkg.sv */
// Purpose: types of the port block
// Assumes: eight pins
// Notes:   no constants here, see the header
package bpop_pkg;

	typedef logic [7:0] bpop_byte_t;

	typedef struct packed {
		logic [7:0] sync1;
		logic [7:0] sync2;
	} bpop_sync_t;

	typedef struct packed {
		bpop_byte_t direction;
		bpop_byte_t latch;
		bpop_byte_t analog;
		bpop_byte_t cfg;
		bpop_byte_t rdata;
	} bpop_state_t;

endpackage

/* design/bpop_pin_if.sv */
// Purpose: carries synchronised pin levels from the synchroniser to the port
// Assumes: one clock domain
// Notes:   level only
`timescale 1ns/10ps
interface bpop_pin_if;
	logic [7:0] level;
	modport src (output level);
	modport dst (input level);
endinterface

/* design/bpop_sync.sv */
// Purpose: two-flop synchroniser for the eight pin inputs
// Assumes: pins are asynchronous to sys_clk_i
// Notes:   first stage read only by the second
`timescale 1ns/10ps
module bpop_sync
(
	// clock and reset
	input  wire logic  sys_clk_i,
	input  wire logic  arst_n_i,
	// pins
	input  wire logic [7:0] pin_raw_i,
	bpop_pin_if.src    pins
);
	bpop_pkg::bpop_sync_t state;
	bpop_pkg::bpop_sync_t next_state;

	always_comb
	begin
		next_state       = state;
		next_state.sync1 = pin_raw_i;
		next_state.sync2 = state.sync1;
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			state <= '0;
		else
			state <= next_state;
	end

	assign pins.level = state.sync2;
endmodule // bpop_sync

/* design/bpop_port.sv */
// Contract
// - eight pins: direction, latch, analog bits
// - direction one: driver off, pin input
// - direction zero: pin driven from latch
// - input-only pin never driven, reads one
// - read returns pins, write hits latch
// - set, clear and toggle writes merge sampled pins into latch
// - reset function on: input-only pin reads zero
// - direction controls drivers on analog pins
// - analog select forces digital reads zero
// - analog select leaves digital output alone
// - highest enabled function owns the pin
// - input functions stay active as output
// - pin0: capcomp3, pwm3a, lcd_segment_42, latch
// - pin1: tx2, ck2, cmp3, lcd_segment_43, latch
// - pin3: capcomp4, pwm3d, lcd_segment_45; pin2: dt2, lcd_segment_44
// - pin4: capcomp5, pwm1d, lcd_segment_26, latch
// - reset fuse off: plain digital input
//
// Purpose: eight-pin port with peripheral output priority
// Assumes: byte registers, read data one cycle after the strobe
// Notes:   pin oe_n low while driving
`timescale 1ns/10ps
`include "bpop_regs.svh"
module bpop_port
(
	// clock and reset
	input  wire logic                    sys_clk_i,
	input  wire logic                    arst_n_i,
	// register port
	input  wire logic [`BPOP_ADDR_W-1:0] addr_i,
	input  wire logic [7:0]              wdata_i,
	input  wire logic                    wr_i,
	input  wire logic                    rd_i,
	output logic      [7:0]              rdata_o,
	// pins
	input  wire logic [7:0]              pin_i,
	output logic      [7:0]              pin_o,
	output logic      [7:0]              pin_oe_n_o,
	// peripheral outputs: enable and value
	input  wire logic                    capcomp_chan3_out_en_i,
	input  wire logic                    capcomp_chan3_out_i,
	input  wire logic                    pwm_chan3_out_a_en_i,
	input  wire logic                    pwm_chan3_out_a_i,
	input  wire logic                    lcd_segment_42_en_i,
	input  wire logic                    lcd_segment_42_i,
	input  wire logic                    serial2_transmit_en_i,
	input  wire logic                    serial2_transmit_i,
	input  wire logic                    serial2_clock_en_i,
	input  wire logic                    serial2_clock_i,
	input  wire logic                    comparator3_output_en_i,
	input  wire logic                    comparator3_output_i,
	input  wire logic                    lcd_segment_43_en_i,
	input  wire logic                    lcd_segment_43_i,
	input  wire logic                    serial2_sync_data_en_i,
	input  wire logic                    serial2_sync_data_i,
	input  wire logic                    lcd_segment_44_en_i,
	input  wire logic                    lcd_segment_44_i,
	input  wire logic                    capcomp_chan4_out_en_i,
	input  wire logic                    capcomp_chan4_out_i,
	input  wire logic                    pwm_chan3_out_d_en_i,
	input  wire logic                    pwm_chan3_out_d_i,
	input  wire logic                    lcd_segment_45_en_i,
	input  wire logic                    lcd_segment_45_i,
	input  wire logic                    capcomp_chan5_out_en_i,
	input  wire logic                    capcomp_chan5_out_i,
	input  wire logic                    pwm_chan1_out_d_en_i,
	input  wire logic                    pwm_chan1_out_d_i,
	input  wire logic                    lcd_segment_26_en_i,
	input  wire logic                    lcd_segment_26_i,
	// digital input view for peripherals and reset
	output logic      [7:0]              pin_digital_o,
	output logic                         ext_reset_n_o
);
	bpop_pin_if pins ();

	bpop_pkg::bpop_state_t state;
	bpop_pkg::bpop_state_t next_state;
	bpop_pkg::bpop_byte_t  port_read;
	bpop_pkg::bpop_byte_t  dir_read;
	logic                  reset_fn;

	// synchronised pin levels
	bpop_sync u_sync
	(
		.sys_clk_i (sys_clk_i),
		.arst_n_i  (arst_n_i),
		.pin_raw_i (pin_i),
		.pins      (pins)
	);

	// reset function active only with fuse set and low-voltage mode off
	assign reset_fn = state.cfg[`BPOP_CFG_RESET_FUSE]
		& ~state.cfg[`BPOP_CFG_LOW_VOLT];

	// digital view of the pins
	function automatic bpop_pkg::bpop_byte_t digital_view(input bpop_pkg::bpop_byte_t lvl,
		input bpop_pkg::bpop_byte_t ana, input logic rst_fn);
		bpop_pkg::bpop_byte_t v;
		v = lvl & ~ana;
		if (rst_fn)
			v[`BPOP_INPUT_ONLY_BIT] = 1'b0;
		return v;
	endfunction

	assign port_read = digital_view(pins.level, state.analog, reset_fn);
	assign dir_read  = state.direction | (8'h01 << `BPOP_INPUT_ONLY_BIT);

	// register file
	always_comb
	begin
		next_state       = state;
		next_state.rdata = 8'h00;
		if (wr_i)
		begin
			case (addr_i)
				`BPOP_OFF_PIN_VALUE: next_state.latch = wdata_i;
				`BPOP_OFF_DIRECTION: next_state.direction = wdata_i;
				`BPOP_OFF_LATCH:     next_state.latch = wdata_i;
				`BPOP_OFF_ANALOG:    next_state.analog = wdata_i;
				`BPOP_OFF_CONFIG:    next_state.cfg = wdata_i & 8'h03;
				// bit writes merge the sampled pins into the latch
				`BPOP_OFF_SET:       next_state.latch = port_read | wdata_i;
				`BPOP_OFF_CLEAR:     next_state.latch = port_read & ~wdata_i;
				`BPOP_OFF_TOGGLE:    next_state.latch = port_read ^ wdata_i;
				default:             next_state.latch = state.latch;
			endcase
		end
		if (rd_i)
		begin
			case (addr_i)
				`BPOP_OFF_PIN_VALUE: next_state.rdata = port_read;
				`BPOP_OFF_DIRECTION: next_state.rdata = dir_read;
				`BPOP_OFF_LATCH:     next_state.rdata = state.latch;
				`BPOP_OFF_ANALOG:    next_state.rdata = state.analog;
				`BPOP_OFF_CONFIG:    next_state.rdata = state.cfg;
				default:             next_state.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state.direction <= `BPOP_DIR_RESET;
			state.latch     <= `BPOP_LATCH_RESET;
			state.analog    <= `BPOP_ANALOG_RESET;
			state.cfg       <= `BPOP_CONFIG_RESET;
			state.rdata     <= 8'h00;
		end
		else
			state <= next_state;
	end

	// output priority per pin, analog select not consulted
	always_comb
	begin
		pin_o = state.latch;
		if (capcomp_chan3_out_en_i)       pin_o[0] = capcomp_chan3_out_i;
		else if (pwm_chan3_out_a_en_i)    pin_o[0] = pwm_chan3_out_a_i;
		else if (lcd_segment_42_en_i)     pin_o[0] = lcd_segment_42_i;
		if (serial2_transmit_en_i)        pin_o[1] = serial2_transmit_i;
		else if (serial2_clock_en_i)      pin_o[1] = serial2_clock_i;
		else if (comparator3_output_en_i) pin_o[1] = comparator3_output_i;
		else if (lcd_segment_43_en_i)     pin_o[1] = lcd_segment_43_i;
		if (serial2_sync_data_en_i)       pin_o[2] = serial2_sync_data_i;
		else if (lcd_segment_44_en_i)     pin_o[2] = lcd_segment_44_i;
		if (capcomp_chan4_out_en_i)       pin_o[3] = capcomp_chan4_out_i;
		else if (pwm_chan3_out_d_en_i)    pin_o[3] = pwm_chan3_out_d_i;
		else if (lcd_segment_45_en_i)     pin_o[3] = lcd_segment_45_i;
		if (capcomp_chan5_out_en_i)       pin_o[4] = capcomp_chan5_out_i;
		else if (pwm_chan1_out_d_en_i)    pin_o[4] = pwm_chan1_out_d_i;
		else if (lcd_segment_26_en_i)     pin_o[4] = lcd_segment_26_i;
		pin_o[7:5] = {state.latch[7:6], 1'b0};
	end

	// drivers follow direction, input-only pin forced off, analog pins included
	always_comb
	begin
		pin_oe_n_o = state.direction;
		pin_oe_n_o[`BPOP_INPUT_ONLY_BIT] = 1'b1;
	end

	// input paths stay live whatever the direction
	assign pin_digital_o = port_read;
	assign ext_reset_n_o = reset_fn ? pins.level[`BPOP_INPUT_ONLY_BIT] : 1'b1;
	assign rdata_o       = state.rdata;
endmodule // bpop_port

/* verif/bpop_port_properties.sv */
// Purpose: port behaviour watched at the top ports
// Assumes: peripheral enables active high
// Notes:   bound after the module
`timescale 1ns/10ps
`include "bpop_regs.svh"
module bpop_port_checker
(
	// watched ports
	input wire logic                    sys_clk_i, arst_n_i, wr_i, rd_i,
	input wire logic [`BPOP_ADDR_W-1:0] addr_i,
	input wire logic [7:0]              wdata_i, rdata_o, pin_o, pin_oe_n_o,
	input wire logic capcomp_chan3_out_en_i, capcomp_chan3_out_i, pwm_chan3_out_a_en_i, pwm_chan3_out_a_i,
	input wire logic lcd_segment_42_en_i, lcd_segment_42_i, serial2_transmit_en_i, serial2_transmit_i,
	input wire logic serial2_clock_en_i, serial2_clock_i, comparator3_output_en_i, comparator3_output_i,
	input wire logic lcd_segment_43_en_i, lcd_segment_43_i, serial2_sync_data_en_i, serial2_sync_data_i,
	input wire logic lcd_segment_44_en_i, lcd_segment_44_i, capcomp_chan4_out_en_i, capcomp_chan4_out_i,
	input wire logic pwm_chan3_out_d_en_i, pwm_chan3_out_d_i, lcd_segment_45_en_i, lcd_segment_45_i,
	input wire logic capcomp_chan5_out_en_i, capcomp_chan5_out_i, pwm_chan1_out_d_en_i, pwm_chan1_out_d_i,
	input wire logic lcd_segment_26_en_i, lcd_segment_26_i
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);
	pin0_priority_a: assert property ((capcomp_chan3_out_en_i | pwm_chan3_out_a_en_i | lcd_segment_42_en_i) |->
		pin_o[0] == (capcomp_chan3_out_en_i ? capcomp_chan3_out_i :
		pwm_chan3_out_a_en_i ? pwm_chan3_out_a_i : lcd_segment_42_i)) else $error("pin0 owner wrong");
	pin1_priority_a: assert property ((serial2_transmit_en_i | serial2_clock_en_i | comparator3_output_en_i |
		lcd_segment_43_en_i) |-> pin_o[1] == (serial2_transmit_en_i ? serial2_transmit_i :
		serial2_clock_en_i ? serial2_clock_i : comparator3_output_en_i ? comparator3_output_i : lcd_segment_43_i))
		else $error("pin1 owner wrong");
	pin2_priority_a: assert property ((serial2_sync_data_en_i | lcd_segment_44_en_i) |->
		pin_o[2] == (serial2_sync_data_en_i ? serial2_sync_data_i : lcd_segment_44_i)) else $error("pin2 owner wrong");
	pin3_priority_a: assert property ((capcomp_chan4_out_en_i | pwm_chan3_out_d_en_i | lcd_segment_45_en_i) |->
		pin_o[3] == (capcomp_chan4_out_en_i ? capcomp_chan4_out_i :
		pwm_chan3_out_d_en_i ? pwm_chan3_out_d_i : lcd_segment_45_i)) else $error("pin3 owner wrong");
	pin4_priority_a: assert property ((capcomp_chan5_out_en_i | pwm_chan1_out_d_en_i | lcd_segment_26_en_i) |->
		pin_o[4] == (capcomp_chan5_out_en_i ? capcomp_chan5_out_i :
		pwm_chan1_out_d_en_i ? pwm_chan1_out_d_i : lcd_segment_26_i)) else $error("pin4 owner wrong");
	input_pin_idle_a: assert property (pin_oe_n_o[5] && !pin_o[5]) else $error("input pin driven");
	dir_write_a: assert property (wr_i && addr_i == `BPOP_OFF_DIRECTION |=>
		pin_oe_n_o == ($past(wdata_i) | 8'h20)) else $error("driver enables wrong");
	dir_read_a: assert property (rd_i && addr_i == `BPOP_OFF_DIRECTION |=> rdata_o[5]) else $error("bit5 not one");
	read_idle_a: assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data outside slot");
	cover property (capcomp_chan3_out_en_i && pwm_chan3_out_a_en_i);
	cover property (serial2_transmit_en_i && serial2_clock_en_i && comparator3_output_en_i);
	cover property (wr_i && addr_i == `BPOP_OFF_DIRECTION);
endmodule // bpop_port_checker
bind bpop_port bpop_port_checker chk_u (.*);

/* verif/bpop_board.sv */
// Purpose: board side of the eight pins
// Assumes: released pins follow a board pattern that is set once
// Notes:   no pull resistors
`timescale 1ns/10ps
module bpop_board
(
	// pin view
	input  wire logic [7:0] pin_o,
	input  wire logic [7:0] pin_oe_n_o,
	input  wire logic [7:0] ext_i,
	output logic      [7:0] pin_i
);
	// driven pins show the port, released ones the board
	assign pin_i = (pin_o & ~pin_oe_n_o) | (ext_i & pin_oe_n_o);
endmodule // bpop_board

/* verif/tb.sv */
// Purpose: self-checking bench of the port
// Assumes: read data one cycle after the strobe
// Notes:   priority checked by the bound checker
`timescale 1ns/10ps
module tb;
	logic       sys_clk_i, arst_n_i, wr_i, rd_i, ext_reset_n_o, rd_d = 1'b0;
	logic [3:0] addr_i;
	logic [7:0] wdata_i, rdata_o, pin_i, pin_o, pin_oe_n_o, pin_digital_o, ext_i, e, a, m, pv;
	logic capcomp_chan3_out_en_i, capcomp_chan3_out_i, pwm_chan3_out_a_en_i, pwm_chan3_out_a_i, lcd_segment_42_en_i,
		lcd_segment_42_i, serial2_transmit_en_i, serial2_transmit_i, serial2_clock_en_i, serial2_clock_i,
		comparator3_output_en_i, comparator3_output_i, lcd_segment_43_en_i, lcd_segment_43_i, serial2_sync_data_en_i,
		serial2_sync_data_i, lcd_segment_44_en_i, lcd_segment_44_i, capcomp_chan4_out_en_i, capcomp_chan4_out_i,
		pwm_chan3_out_d_en_i, pwm_chan3_out_d_i, lcd_segment_45_en_i, lcd_segment_45_i, capcomp_chan5_out_en_i,
		capcomp_chan5_out_i, pwm_chan1_out_d_en_i, pwm_chan1_out_d_i, lcd_segment_26_en_i, lcd_segment_26_i;
	int         miscompares = 0, checks = 0, cyc = 0, seed = 32'hd88a;
	logic [7:0] exp_q[$];
	bpop_port dut_u (.*);
	bpop_board board_u (.*);
	initial
	begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end
	task per(input logic [29:0] v);
		{capcomp_chan3_out_en_i, capcomp_chan3_out_i, pwm_chan3_out_a_en_i, pwm_chan3_out_a_i, lcd_segment_42_en_i,
		lcd_segment_42_i, serial2_transmit_en_i, serial2_transmit_i, serial2_clock_en_i, serial2_clock_i,
		comparator3_output_en_i, comparator3_output_i, lcd_segment_43_en_i, lcd_segment_43_i, serial2_sync_data_en_i,
		serial2_sync_data_i, lcd_segment_44_en_i, lcd_segment_44_i, capcomp_chan4_out_en_i, capcomp_chan4_out_i,
		pwm_chan3_out_d_en_i, pwm_chan3_out_d_i, lcd_segment_45_en_i, lcd_segment_45_i, capcomp_chan5_out_en_i,
		capcomp_chan5_out_i, pwm_chan1_out_d_en_i, pwm_chan1_out_d_i, lcd_segment_26_en_i, lcd_segment_26_i} <= v;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] x);
		checks++;
		if (got !== x)
		begin
			miscompares++;
			$display("mismatch %0t got %h expected %h", $time, got, x);
		end
	endtask
	task wr(input logic [3:0] ad, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr_i <= ad;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask
	task rd(input logic [3:0] ad, input logic [7:0] x);
		@(posedge sys_clk_i);
		addr_i <= ad;
		rd_i <= 1'b1;
		exp_q.push_back(x);
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
	endtask
	task complete_run;
		if (miscompares == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// scoreboard and hang guard
	always @(posedge sys_clk_i)
	begin
		if (rd_d)
			chk(rdata_o, exp_q.pop_front());
		rd_d <= rd_i;
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			miscompares++;
			complete_run;
		end
	end
	initial
	begin
		{arst_n_i, addr_i, wdata_i, wr_i, rd_i, ext_i} = '0;
		per(30'h0);
		repeat (3) @(posedge sys_clk_i);
		arst_n_i <= 1'b1;
		rd(4'h1, 8'hff);
		rd(4'h2, 8'h00);
		rd(4'h3, 8'hff);
		rd(4'h9, 8'h00);
		rd(4'h0, 8'h00);
		e = 8'($random(seed));
		a = 8'($random(seed));
		m = 8'($random(seed));
		pv = {a[7:6], e[5], a[4:0]};
		ext_i <= e;
		wr(4'h3, 8'h00);
		repeat (4) @(posedge sys_clk_i);
		rd(4'h0, e);
		wr(4'h1, 8'h00);
		wr(4'h2, a);
		rd(4'h1, 8'h20);
		repeat (4) @(posedge sys_clk_i);
		rd(4'h0, pv);
		wr(4'h7, m);
		rd(4'h2, pv ^ m);
		wr(4'h3, 8'hff);
		chk(pin_o, (pv ^ m) & 8'hdf);
		rd(4'h0, 8'h00);
		wr(4'h5, 8'h01);
		rd(4'h2, 8'h01);
		wr(4'h3, 8'h00);
		wr(4'h4, 8'hff);
		rd(4'h4, 8'h03);
		repeat (4) @(posedge sys_clk_i);
		rd(4'h0, {2'b00, e[5], 5'h01});
		chk(pin_digital_o, {2'b00, e[5], 5'h01});
		chk({7'h00, ext_reset_n_o}, 8'h01);
		wr(4'h4, 8'h01);
		repeat (4) @(posedge sys_clk_i);
		rd(4'h0, 8'h01);
		chk(pin_digital_o, 8'h01);
		chk({7'h00, ext_reset_n_o}, {7'h00, e[5]});
		repeat (200)
		begin
			per(30'($random(seed)));
			wr(4'h1, 8'($random(seed)));
		end
		complete_run;
	end
endmodule // tb
